// ### pirq_flags.sv
// Sticky event flags, their masks and the active-low interrupt pin
`timescale 1ns/1ps
module pirq_flags
  import pirq_pkg::*;
(
  input wire logic clk_i,
  input wire logic srst_i,
  pirq_irq_if.flag irq
);
  logic [1:0] flags;
  logic [1:0] mask;
  logic int_n;
  wire [1:0] next_flags;
  wire pending;

  // ==========================================================================
  // Flag update: set beats clear in the same cycle
  // ==========================================================================
  assign next_flags = (flags & ~irq.clr) | irq.evt; // [R09] [R10] [R12]
  assign pending = |(flags & mask); // [R11] [R14]

  // Flag, mask and pin registers
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      flags <= PIRQ_RST_FLAGS;
      mask <= PIRQ_RST_MASK; // [R13]
      int_n <= 1'b1;
    end else begin
      flags <= next_flags;
      if (irq.mask_wr) begin
        mask <= irq.mask_wdata; // [R13]
      end
      int_n <= ~pending; // [R11] [R14]
    end
  end

  assign irq.flags = flags;
  assign irq.mask = mask;
  assign irq.int_n = int_n;

  // ==========================================================================
  // Checks
  // ==========================================================================
  chk_set_beats_clear: assert property (@(posedge clk_i) disable iff (srst_i) // [R12]
    irq.evt[0] && irq.clr[0] |=> flags[0])
    else $error("object flag lost when set and clear coincide");
  chk_clear_by_one: assert property (@(posedge clk_i) disable iff (srst_i) // [R12]
    irq.clr[1] && !irq.evt[1] |=> !flags[1])
    else $error("histogram flag not cleared by write of one");
  chk_zero_keeps_flag: assert property (@(posedge clk_i) disable iff (srst_i) // [R12]
    flags[0] && !irq.clr[0] |=> flags[0])
    else $error("object flag dropped without a clear");
  chk_hist_sets_flag: assert property (@(posedge clk_i) disable iff (srst_i) // [R09]
    irq.evt[1] |=> flags[1])
    else $error("histogram event did not set its flag");
  chk_obj_sets_flag: assert property (@(posedge clk_i) disable iff (srst_i) // [R10]
    irq.evt[0] |=> flags[0])
    else $error("object event did not set its flag");
  chk_pin_low_masked: assert property (@(posedge clk_i) disable iff (srst_i) // [R11]
    (flags[1] && mask[1]) |=> !int_n)
    else $error("interrupt pin not low for an enabled flag");
  chk_pin_release: assert property (@(posedge clk_i) disable iff (srst_i) // [R14]
    !(|(flags & mask)) |=> int_n)
    else $error("interrupt pin low with no enabled flag");
  chk_mask_blocks: assert property (@(posedge clk_i) disable iff (srst_i) // [R13]
    (mask == 2'h0) [*2] |-> int_n)
    else $error("interrupt pin low while all masks are zero");
endmodule : pirq_flags

// ### pirq_host_model.sv
// Host controller model issuing single-byte register accesses
`timescale 1ns/1ps
module pirq_host_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic rvalid_i,
  input wire logic mmio_rd_i,
  input wire logic mmio_wr_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  logic seen_valid;
  logic seen_wr;
  // Idle bus at time zero
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    seen_valid = 1'b0;
    seen_wr = 1'b0;
  end
  // One byte write; released lines show inverted values, never the old ones
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    #1 seen_wr = mmio_wr_i;
    @(negedge clk_i);
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  // One byte read; data taken while the valid pulse stands
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d, output logic mm);
    @(negedge clk_i);
    addr_o = a;
    rd_o = 1'b1;
    #1 mm = mmio_rd_i;
    @(negedge clk_i);
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
    seen_valid = rvalid_i;
  endtask
endmodule // pirq_host_model

// ### pirq_irq_if.sv
// Interface between the register bank and the event flag block
`timescale 1ns/1ps
interface pirq_irq_if;
  logic [1:0] evt;
  logic [1:0] clr;
  logic [1:0] mask_wdata;
  logic mask_wr;
  logic [1:0] flags;
  logic [1:0] mask;
  logic int_n;
  modport ctrl (output evt, output clr, output mask_wdata, output mask_wr,
                input flags, input mask, input int_n);
  modport flag (input evt, input clr, input mask_wdata, input mask_wr,
                output flags, output mask, output int_n);
endinterface : pirq_irq_if

// ### pirq_pkg.sv
// Package with register map, field positions and timing counts for the power and interrupt status bank
package pirq_pkg;
  // ==========================================================================
  // Register offsets
  // ==========================================================================
  localparam logic [7:0] PIRQ_ADDR_POWER_CONTROL = 8'he0;
  localparam logic [7:0] PIRQ_ADDR_INTERRUPT_FLAGS = 8'he1;
  localparam logic [7:0] PIRQ_ADDR_INTERRUPT_MASK = 8'he2;
  localparam logic [7:0] PIRQ_ADDR_ALWAYS_ON_BASE = 8'he0;
  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int PIRQ_BIT_CORE_RESTART = 7;
  localparam int PIRQ_BIT_CORE_READY = 6;
  localparam int PIRQ_BIT_POWER_ON = 0;
  localparam int PIRQ_BIT_OBJECT_RESULT = 0;
  localparam int PIRQ_BIT_HISTOGRAM_READY = 1;
  localparam int PIRQ_EVENT_COUNT = 2;
  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [1:0] PIRQ_RST_FLAGS = 2'h0;
  localparam logic [1:0] PIRQ_RST_MASK = 2'h0;
  localparam logic [7:0] PIRQ_RST_RDATA = 8'h00;
  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int PIRQ_CLK_PERIOD_NS = 20;
  localparam int PIRQ_CORE_RESET_NS = 80;
  localparam int PIRQ_CORE_RESET_CYCLES = (PIRQ_CORE_RESET_NS + PIRQ_CLK_PERIOD_NS - 1) / PIRQ_CLK_PERIOD_NS;
endpackage : pirq_pkg

// ### pirq_power_regs.sv
// Power control and interrupt status register bank of the sensor
//
// Overview of operation
// R01 - Restart bit write applies global core reset
// R02 - Restart bit clears itself after the reset
// R03 - Not ready: only 0xe0 and above usable
// R04 - Ready flag read-only, set only by firmware
// R05 - Power-on rising write starts oscillator, wakes core
// R06 - Boot resets on wake; application goes idle
// R07 - Power-on zero write interrupts core, oscillator stays
// R08 - Firmware shuts modules down, then enters standby
// R09 - Histogram flag bit 1 sets on histogram
// R10 - Object flag bit 0 sets on result
// R11 - Enabled set flag drives interrupt pin low
// R12 - Write one clears flag, zero leaves it
// R13 - Mask bits per event, reset zero, one enables
// R14 - Pin returns high when no enabled flag
`timescale 1ns/1ps
module pirq_power_regs
  import pirq_pkg::*;
#(
  parameter int CORE_RESET_CYCLES = PIRQ_CORE_RESET_CYCLES
)
(
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  output logic mmio_wr_o,
  output logic mmio_rd_o,
  input wire logic [7:0] mmio_rdata_i,
  input wire logic fw_set_ready_i,
  input wire logic fw_clr_ready_i,
  input wire logic fw_standby_i,
  input wire logic object_result_evt_i,
  input wire logic histogram_ready_evt_i,
  output logic core_reset_o,
  output logic osc_enable_o,
  output logic wake_interrupt_o,
  output logic sleep_interrupt_o,
  output logic core_ready_o,
  output logic int_n_o
);
  // Width of the restart counter and its load value
  localparam int CW = $clog2(CORE_RESET_CYCLES + 1);
  localparam logic [CW-1:0] RESET_LOAD = CW'(CORE_RESET_CYCLES);

  pirq_irq_if irq ();

  logic [CW-1:0] reset_cnt;
  logic osc_enable;
  logic core_ready;
  logic wake_pulse;
  logic sleep_pulse;
  logic [7:0] rdata;
  logic rvalid;

  // ==========================================================================
  // Address decode
  // ==========================================================================
  wire sel_power = reg_addr_i == PIRQ_ADDR_POWER_CONTROL;
  wire sel_flags = reg_addr_i == PIRQ_ADDR_INTERRUPT_FLAGS;
  wire sel_mask = reg_addr_i == PIRQ_ADDR_INTERRUPT_MASK;
  wire sel_mmio = reg_addr_i < PIRQ_ADDR_ALWAYS_ON_BASE;
  // Power register write actions: restart, wake on a rising write, sleep on a falling one
  wire wr_power = reg_wr_i && sel_power;
  wire restart_req = wr_power && reg_wdata_i[PIRQ_BIT_CORE_RESTART]; // [R01]
  wire core_reset = reset_cnt != '0;
  wire wake_req = wr_power && reg_wdata_i[PIRQ_BIT_POWER_ON] && !osc_enable; // [R05]
  wire sleep_req = wr_power && !reg_wdata_i[PIRQ_BIT_POWER_ON] && osc_enable; // [R07]
  wire mmio_open = core_ready && sel_mmio; // [R03]

  // Core restart counter, reloaded by each restart write
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reset_cnt <= '0;
    end else if (restart_req) begin
      reset_cnt <= RESET_LOAD; // [R01]
    end else if (core_reset) begin
      reset_cnt <= reset_cnt - CW'(1); // [R02]
    end
  end

  // Oscillator request and core interrupt pulses
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      osc_enable <= 1'b0;
      wake_pulse <= 1'b0;
      sleep_pulse <= 1'b0;
    end else begin
      wake_pulse <= wake_req; // [R05] [R06]
      sleep_pulse <= sleep_req; // [R07]
      if (wake_req) begin
        osc_enable <= 1'b1; // [R05]
      end else if (fw_standby_i) begin
        osc_enable <= 1'b0; // [R08]
      end
    end
  end

  // Ready flag: firmware sets it, core reset wipes it
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      core_ready <= 1'b0;
    end else if (core_reset || fw_clr_ready_i) begin
      core_ready <= 1'b0; // [R01]
    end else if (fw_set_ready_i) begin
      core_ready <= 1'b1; // [R04]
    end
  end

  // ==========================================================================
  // Event flags and mask
  // ==========================================================================
  assign irq.evt = {histogram_ready_evt_i, object_result_evt_i}; // [R09] [R10]
  assign irq.clr = (reg_wr_i && sel_flags) ? reg_wdata_i[1:0] : 2'h0; // [R12]
  assign irq.mask_wr = reg_wr_i && sel_mask;
  assign irq.mask_wdata = reg_wdata_i[1:0];

  // Flag block, reached through the shared interface
  pirq_flags u_flags (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .irq(irq)
  );

  // ==========================================================================
  // Read path
  // ==========================================================================
  // Power register view and the read select
  wire [7:0] power_view = {core_reset, core_ready, 5'h00, osc_enable}; // [R02] [R04]
  wire [7:0] read_mux = sel_power ? power_view :
                        sel_flags ? {6'h00, irq.flags} :
                        sel_mask ? {6'h00, irq.mask} :
                        mmio_open ? mmio_rdata_i : 8'h00; // [R03]

  // Registered read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rdata <= PIRQ_RST_RDATA;
      rvalid <= 1'b0;
    end else begin
      rvalid <= reg_rd_i;
      if (reg_rd_i) begin
        rdata <= read_mux;
      end
    end
  end

  assign reg_rdata_o = rdata;
  assign reg_rvalid_o = rvalid;
  assign mmio_wr_o = reg_wr_i && mmio_open; // [R03]
  assign mmio_rd_o = reg_rd_i && mmio_open; // [R03]
  assign core_reset_o = core_reset;
  assign osc_enable_o = osc_enable;
  assign wake_interrupt_o = wake_pulse;
  assign sleep_interrupt_o = sleep_pulse;
  assign core_ready_o = core_ready;
  assign int_n_o = irq.int_n;

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_restart_write;
    wr_power && reg_wdata_i[PIRQ_BIT_CORE_RESTART];
  endsequence
  sequence s_quiet_window;
    !restart_req [*4];
  endsequence
  sequence s_reset_window;
    core_reset && $past(core_reset) && $past(core_reset, 2) && $past(core_reset, 3) ##1 !core_reset;
  endsequence

  // Restart window: four cycles of core reset, then the bit clears itself
  chk_restart_resets: assert property (@(posedge clk_i) disable iff (srst_i) // [R01]
    s_restart_write ##1 s_quiet_window |-> s_reset_window)
    else $error("restart write did not give the reset window");
  chk_restart_selfclr: assert property (@(posedge clk_i) disable iff (srst_i) // [R02]
    core_reset && !restart_req |=> reset_cnt == $past(reset_cnt) - CW'(1))
    else $error("restart counter did not count down alone");
  chk_ready_cleared: assert property (@(posedge clk_i) disable iff (srst_i) // [R01]
    core_reset |=> !core_ready)
    else $error("ready flag survived the core reset");

  // Ready, gating, power bit and flag read checks
  chk_ready_by_fw: assert property (@(posedge clk_i) disable iff (srst_i) // [R04]
    $rose(core_ready) |-> $past(fw_set_ready_i) && !$past(core_reset))
    else $error("ready flag rose without firmware");
  chk_mmio_gated: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
    !core_ready |-> !mmio_wr_o && !mmio_rd_o)
    else $error("memory space touched while core not ready");
  chk_wake_on_rise: assert property (@(posedge clk_i) disable iff (srst_i) // [R05]
    wake_req |=> osc_enable && wake_interrupt_o ##1 !wake_interrupt_o)
    else $error("power-on write did not start oscillator and wake");
  chk_sleep_request: assert property (@(posedge clk_i) disable iff (srst_i) // [R07]
    sleep_req && !fw_standby_i |=> sleep_interrupt_o && osc_enable)
    else $error("power-off write not forwarded to the core");
  chk_standby_stops: assert property (@(posedge clk_i) disable iff (srst_i) // [R08]
    fw_standby_i && !wake_req |=> !osc_enable)
    else $error("firmware standby did not stop oscillator");
  chk_read_latency: assert property (@(posedge clk_i) disable iff (srst_i) // [R12]
    reg_rd_i && sel_flags |=> reg_rvalid_o && reg_rdata_o[7:2] == 6'h00)
    else $error("flag read answer late or reserved bits set");

  // Read path and power bit edge checks
  chk_rvalid_single: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
    !reg_rd_i |=> !reg_rvalid_o)
    else $error("read valid without a read strobe");
  chk_mmio_read_zero: assert property (@(posedge clk_i) disable iff (srst_i) // [R03]
    reg_rd_i && sel_mmio && !core_ready |=> reg_rdata_o == 8'h00)
    else $error("memory space read gave data while core not ready");
  chk_osc_hold: assert property (@(posedge clk_i) disable iff (srst_i) // [R07]
    !wake_req && !fw_standby_i |=> $stable(osc_enable))
    else $error("oscillator changed without wake or standby");
  chk_wake_only_rise: assert property (@(posedge clk_i) disable iff (srst_i) // [R05]
    wr_power && osc_enable |=> !wake_interrupt_o)
    else $error("wake pulse while oscillator already running");
  chk_sleep_only_on: assert property (@(posedge clk_i) disable iff (srst_i) // [R07]
    wr_power && !reg_wdata_i[PIRQ_BIT_POWER_ON] && !osc_enable |=> !sleep_interrupt_o)
    else $error("sleep pulse while oscillator already stopped");
endmodule : pirq_power_regs

// ### tb_top.sv
// Self-checking testbench for the power and interrupt status bank
`timescale 1ns/1ps
module tb_top;
  import pirq_pkg::*;
  localparam int RST_CYC = 4;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, d;
  logic wr, rd, rvalid, mwr, mrd, m;
  logic set_rdy = 1'b0, clr_rdy = 1'b0, stby = 1'b0;
  logic [1:0] evt = 2'h0;
  logic core_rst, osc, wake, sleep, rdy, int_n;
  int error_cnt = 0, cmp_count = 0, wake_cnt = 0, sleep_cnt = 0, n;
  // ==========================================================================
  // Design, host model and clock
  // ==========================================================================
  pirq_power_regs #(.CORE_RESET_CYCLES(RST_CYC)) DUT (.clk_i(clk_i), .srst_i(srst_i),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .mmio_wr_o(mwr), .mmio_rd_o(mrd), .mmio_rdata_i(8'h5a),
    .fw_set_ready_i(set_rdy), .fw_clr_ready_i(clr_rdy), .fw_standby_i(stby),
    .object_result_evt_i(evt[0]), .histogram_ready_evt_i(evt[1]), .core_reset_o(core_rst),
    .osc_enable_o(osc), .wake_interrupt_o(wake), .sleep_interrupt_o(sleep), .core_ready_o(rdy),
    .int_n_o(int_n));
  pirq_host_model host (.clk_i(clk_i), .rdata_i(rdata), .rvalid_i(rvalid), .mmio_rd_i(mrd), .mmio_wr_i(mwr),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  always #10 clk_i = ~clk_i;
  // Count one-cycle pulses to the core
  always @(posedge clk_i) begin
    wake_cnt <= wake_cnt + int'(wake);
    sleep_cnt <= sleep_cnt + int'(sleep);
  end
  // ==========================================================================
  // Helpers
  // ==========================================================================
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      error_cnt++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_i);
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic t_gate;
    host.rd_reg(8'h10, d, m);
    chk("low read data", 8'h00, d);
    chk("mmio rd strobe", 8'h00, {7'h0, m});
    chk("read valid", 8'h01, {7'h0, host.seen_valid});
    cyc(1);
    chk("valid pulse", 8'h00, {7'h0, rvalid});
    host.wr_reg(8'h10, 8'h33);
    chk("mmio wr gated", 8'h00, {7'h0, host.seen_wr});
    host.wr_reg(8'he0, 8'h40);
    host.rd_reg(PIRQ_ADDR_POWER_CONTROL, d, m);
    chk("ready by host", 8'h00, d);
    set_rdy = 1'b1;
    cyc(1);
    set_rdy = 1'b0;
    cyc(1);
    host.rd_reg(PIRQ_ADDR_POWER_CONTROL, d, m);
    chk("ready by fw", 8'h40, d);
    host.rd_reg(8'h10, d, m);
    chk("mapped read", 8'h5a, d);
    chk("mmio rd open", 8'h01, {7'h0, m});
    host.wr_reg(8'h10, 8'h33);
    chk("mmio wr open", 8'h01, {7'h0, host.seen_wr});
    clr_rdy = 1'b1;
    cyc(1);
    clr_rdy = 1'b0;
    chk("ready fw clear", 8'h00, {7'h0, rdy});
    set_rdy = 1'b1;
    cyc(1);
    set_rdy = 1'b0;
    chk("ready again", 8'h01, {7'h0, rdy});
  endtask
  task automatic t_restart;
    host.wr_reg(PIRQ_ADDR_POWER_CONTROL, 8'h80);
    n = 0;
    for (int i = 0; i < 12; i++) begin
      set_rdy = (i == 1);
      if (core_rst === 1'b1) n++;
      cyc(1);
    end
    chk("reset length", 8'(RST_CYC), 8'(n));
    chk("ready cleared", 8'h00, {7'h0, rdy});
    host.rd_reg(PIRQ_ADDR_POWER_CONTROL, d, m);
    chk("restart cleared", 8'h00, d);
  endtask
  task automatic t_power;
    int w0, s0;
    w0 = wake_cnt;
    s0 = sleep_cnt;
    host.wr_reg(PIRQ_ADDR_POWER_CONTROL, 8'h01);
    cyc(2);
    chk("osc on", 8'h01, {7'h0, osc});
    host.wr_reg(PIRQ_ADDR_POWER_CONTROL, 8'h01);
    cyc(2);
    chk("wake pulses", 8'h01, 8'(wake_cnt - w0));
    host.wr_reg(PIRQ_ADDR_POWER_CONTROL, 8'h00);
    cyc(2);
    chk("sleep pulses", 8'h01, 8'(sleep_cnt - s0));
    chk("osc kept", 8'h01, {7'h0, osc});
    stby = 1'b1;
    cyc(1);
    stby = 1'b0;
    cyc(2);
    chk("osc standby", 8'h00, {7'h0, osc});
  endtask
  task automatic t_flags;
    for (int i = 0; i < 2; i++) begin
      evt[i] = 1'b1;
      cyc(1);
      evt[i] = 1'b0;
      cyc(3);
      host.rd_reg(PIRQ_ADDR_INTERRUPT_FLAGS, d, m);
      chk("flag set", 8'h01 << i, d);
      chk("masked pin", 8'h01, {7'h0, int_n});
      host.wr_reg(PIRQ_ADDR_INTERRUPT_MASK, 8'h01 << i);
      cyc(3);
      chk("pin low", 8'h00, {7'h0, int_n});
      host.wr_reg(PIRQ_ADDR_INTERRUPT_FLAGS, ~(8'h01 << i));
      host.rd_reg(PIRQ_ADDR_INTERRUPT_FLAGS, d, m);
      chk("zero keeps", 8'h01 << i, d);
      host.wr_reg(PIRQ_ADDR_INTERRUPT_FLAGS, 8'h01 << i);
      cyc(3);
      chk("pin high", 8'h01, {7'h0, int_n});
      host.rd_reg(PIRQ_ADDR_INTERRUPT_FLAGS, d, m);
      chk("one clears", 8'h00, d);
      host.wr_reg(PIRQ_ADDR_INTERRUPT_MASK, 8'h00);
    end
    // Event and clear of the same flag in one cycle: the event wins
    fork
      host.wr_reg(PIRQ_ADDR_INTERRUPT_FLAGS, 8'h01);
      begin
        @(negedge clk_i);
        evt[0] = 1'b1;
        @(negedge clk_i);
        evt[0] = 1'b0;
      end
    join
    host.rd_reg(PIRQ_ADDR_INTERRUPT_FLAGS, d, m);
    chk("set beats clear", 8'h01, d);
    host.wr_reg(PIRQ_ADDR_INTERRUPT_FLAGS, 8'h01);
    host.rd_reg(PIRQ_ADDR_INTERRUPT_FLAGS, d, m);
    chk("late clear", 8'h00, d);
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    cyc(8);
    srst_i = 1'b0;
    host.rd_reg(PIRQ_ADDR_INTERRUPT_MASK, d, m);
    chk("mask reset", 8'h00, d);
    t_gate();
    t_restart();
    t_power();
    t_flags();
    close_out();
  end
  initial begin
    #(20 * 2000);
    error_cnt++;
    close_out();
  end
endmodule // tb_top
